// file: core/tca_pkg.sv
/*
  Constants for the channel-adjust opcode host controller.
  Assumes a device with a 16-bit command/data port and a handshake.
*/
package tca_pkg;

  // ****************************************************************
  // Opcode high bytes
  // ****************************************************************
  localparam logic [7:0] OP_EN_ONE = 8'h40;
  localparam logic [7:0] OP_DIS_ONE = 8'h41;
  localparam logic [7:0] OP_EN_ALL = 8'h42;
  localparam logic [7:0] OP_DIS_ALL = 8'h43;
  localparam logic [7:0] OP_WR_MASK = 8'h44;
  localparam logic [7:0] OP_RD_MASK = 8'h45;
  localparam logic [7:0] OP_WR_MASK32 = 8'h46;
  localparam logic [7:0] OP_RD_MASK32 = 8'h47;
  localparam logic [7:0] OP_WR_GOFS = 8'h50;
  localparam logic [7:0] OP_RD_GOFS = 8'h51;
  localparam logic [7:0] OP_WR_CHOFS = 8'h52;
  localparam logic [7:0] OP_RD_CHOFS = 8'h53;
  localparam logic [7:0] OP_WR_CAL = 8'h54;
  localparam logic [7:0] OP_RD_CAL = 8'h55;
  localparam logic [7:0] OP_SAVE_CAL = 8'h56;
  localparam logic [7:0] OP_RD_ID = 8'h60;
  localparam logic [7:0] OP_RD_FW = 8'h61;
  localparam logic [7:0] OP_RST_LOOPS = 8'h62;

  // ****************************************************************
  // Host register map (word indices on the local port)
  // ****************************************************************
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_WDATA0 = 4'h1;
  localparam logic [3:0] REG_WDATA1 = 4'h2;
  localparam logic [3:0] REG_RDATA0 = 4'h3;
  localparam logic [3:0] REG_RDATA1 = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_CONFIG = 4'h6;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_BADOP = 2;
  localparam int CFG_NARROW = 0;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] LOW_BYTE_MASK = 8'hFF;
  localparam logic [15:0] CHOFS_MASK = 16'h00FF;
  localparam logic [15:0] CAL_MASK = 16'h0FFF;
  localparam logic [15:0] COARSE_MASK = 16'h07FF;
  localparam logic [15:0] FINE_MASK = 16'h001F;

endpackage

// file: core/tca_opdec.sv
/*
  Opcode decoder: data-word count and direction per opcode.
  Assumes the opcode is stable while the sequencer reads it.
*/
`timescale 1ns/1ns
`default_nettype none
module tca_opdec (
  input wire logic [15:0] opcode,
  input wire logic narrow,
  output logic [1:0] n_words,
  output logic is_read,
  output logic known
);

  // ****************************************************************
  // Word count decode
  // ****************************************************************
  always_comb begin
    n_words = 2'd0;
    is_read = 1'b0;
    known = 1'b1;
    unique case (opcode[15:8])
      tca_pkg::OP_EN_ONE, tca_pkg::OP_DIS_ONE, tca_pkg::OP_EN_ALL,
      tca_pkg::OP_DIS_ALL, tca_pkg::OP_SAVE_CAL,
      tca_pkg::OP_RST_LOOPS: begin
        n_words = 2'd0;
      end
      tca_pkg::OP_WR_MASK: begin
        n_words = narrow ? 2'd1 : 2'd2;
      end
      tca_pkg::OP_RD_MASK: begin
        n_words = narrow ? 2'd1 : 2'd2;
        is_read = 1'b1;
      end
      tca_pkg::OP_WR_MASK32, tca_pkg::OP_WR_GOFS: begin
        n_words = 2'd2;
      end
      tca_pkg::OP_RD_MASK32, tca_pkg::OP_RD_GOFS: begin
        n_words = 2'd2;
        is_read = 1'b1;
      end
      tca_pkg::OP_WR_CHOFS, tca_pkg::OP_WR_CAL: begin
        n_words = 2'd1;
      end
      tca_pkg::OP_RD_CHOFS, tca_pkg::OP_RD_CAL, tca_pkg::OP_RD_ID,
      tca_pkg::OP_RD_FW: begin
        n_words = 2'd1;
        is_read = 1'b1;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// file: core/tca_host.sv
/*
  Host controller for the converter board's channel-adjust opcodes.
  Software loads a command and data words through a local register port;
  this block drives the device command/data port with a request/ack
  handshake. Assumes dev_ack arrives from another clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
// Operation
// - 44xx then two mask words written (one if narrow); bit k is channel.
// - 45xx then two mask words read back (one if narrow), same mapping.
// - 460n then two words form converter n's 32-channel mask.
// - 470n then converter n's mask read as two words.
// - 50xx then coarse offset word, then fine offset word.
// - 51xx reads coarse offset then fine offset.
// - 52nn then one word; low 8 bits are channel nn offset.
// - 53nn reads channel nn offset in low 8 bits.
// - 540n then one word; low 12 bits set converter n calibration.
// - 550n transfers converter n calibration, twelve low bits; read here.
// - 600n reads converter n identification code, one word.
// - 61xx reads firmware revision in low 8 bits.
module tca_host (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  output logic dev_req,
  output logic dev_we,
  output logic [15:0] dev_wdata,
  input wire logic [15:0] dev_rdata,
  input wire logic dev_ack
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_OPC = 5'b00010,
    ST_DATA = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_DONE = 5'b10000
  } tca_state_t;

  tca_state_t state_q, state_d;
  logic [15:0] cmd_q, cmd_d;
  logic [15:0] wd0_q, wd0_d, wd1_q, wd1_d;
  logic [15:0] rd0_q, rd0_d, rd1_q, rd1_d;
  logic [15:0] cfg_q, cfg_d;
  logic [1:0] idx_q, idx_d;
  logic badop_q, badop_d;
  logic done_q, done_d;
  logic [15:0] sw_rdata_q, sw_rdata_d;
  logic req_q, req_d;
  logic we_q, we_d;
  logic [15:0] dwd_q, dwd_d;
  logic ack_s1_q, ack_s2_q, ack_s3_q;
  logic ack_lvl_q, ack_lvl_d;
  logic [1:0] n_words;
  logic is_read, known;
  logic second_w;

  tca_opdec u_dec (
    .opcode(cmd_q),
    .narrow(cfg_q[tca_pkg::CFG_NARROW]),
    .n_words(n_words),
    .is_read(is_read),
    .known(known)
  );

  assign second_w = (idx_q == 2'd2);

  // ****************************************************************
  // Data word masking for write commands
  // ****************************************************************
  function automatic logic [15:0] wr_mask(input logic [7:0] op,
                                          input logic [15:0] w,
                                          input logic second);
    logic [15:0] r;
    r = w;
    if (op == tca_pkg::OP_WR_CHOFS) begin
      r = w & tca_pkg::CHOFS_MASK;
    end else if (op == tca_pkg::OP_WR_CAL) begin
      r = w & tca_pkg::CAL_MASK;
    end else if (op == tca_pkg::OP_WR_GOFS) begin
      r = second ? (w & tca_pkg::FINE_MASK)
                 : (w & tca_pkg::COARSE_MASK);
    end
    return r;
  endfunction

  // First data word at index 1, second at index 2
  function automatic logic [15:0] pick_word(input logic [1:0] i,
                                            input logic [15:0] w0,
                                            input logic [15:0] w1);
    logic [15:0] r;
    r = w0;
    if (i == 2'd2) begin
      r = w1;
    end
    return r;
  endfunction

  // Opcode with low byte cleared where it is ignored
  function automatic logic [15:0] op_word(input logic [15:0] c);
    logic [15:0] r;
    r = c;
    unique case (c[15:8])
      tca_pkg::OP_EN_ALL, tca_pkg::OP_DIS_ALL, tca_pkg::OP_WR_MASK,
      tca_pkg::OP_RD_MASK, tca_pkg::OP_WR_GOFS, tca_pkg::OP_RD_GOFS,
      tca_pkg::OP_SAVE_CAL, tca_pkg::OP_RD_FW,
      tca_pkg::OP_RST_LOOPS: begin
        r = {c[15:8], 8'h00};
      end
      tca_pkg::OP_WR_MASK32, tca_pkg::OP_RD_MASK32, tca_pkg::OP_WR_CAL,
      tca_pkg::OP_RD_CAL, tca_pkg::OP_RD_ID: begin
        r = {c[15:8], 4'h0, c[3:0]};
      end
      default: begin
        r = c;
      end
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Acknowledge synchroniser
  // ****************************************************************
  always_comb begin
    ack_lvl_d = ack_lvl_q;
    if (ack_s2_q == ack_s3_q) begin
      ack_lvl_d = ack_s3_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      ack_lvl_q <= 1'b0;
    end else begin
      ack_s1_q <= dev_ack;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      ack_lvl_q <= ack_lvl_d;
    end
  end

  // ****************************************************************
  // Sequencer and software registers
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    wd0_d = wd0_q;
    wd1_d = wd1_q;
    rd0_d = rd0_q;
    rd1_d = rd1_q;
    cfg_d = cfg_q;
    idx_d = idx_q;
    badop_d = badop_q;
    done_d = done_q;
    req_d = req_q;
    we_d = we_q;
    dwd_d = dwd_q;
    sw_rdata_d = tca_pkg::WORD_RESET;
    if (sw_rd) begin
      unique case (sw_addr)
        tca_pkg::REG_CMD: sw_rdata_d = cmd_q;
        tca_pkg::REG_WDATA0: sw_rdata_d = wd0_q;
        tca_pkg::REG_WDATA1: sw_rdata_d = wd1_q;
        tca_pkg::REG_RDATA0: sw_rdata_d = rd0_q;
        tca_pkg::REG_RDATA1: sw_rdata_d = rd1_q;
        tca_pkg::REG_STATUS: begin
          sw_rdata_d = {13'h0000, badop_q, done_q, state_q != ST_IDLE};
        end
        tca_pkg::REG_CONFIG: sw_rdata_d = cfg_q;
        default: sw_rdata_d = tca_pkg::WORD_RESET;
      endcase
    end
    if (sw_wr && state_q == ST_IDLE) begin
      unique case (sw_addr)
        tca_pkg::REG_WDATA0: wd0_d = sw_wdata;
        tca_pkg::REG_WDATA1: wd1_d = sw_wdata;
        tca_pkg::REG_CONFIG: cfg_d = sw_wdata;
        default: begin
        end
      endcase
    end
    unique case (state_q)
      ST_IDLE: begin
        // Command write launches; needs no run/stop gating
        if (sw_wr && sw_addr == tca_pkg::REG_CMD) begin
          cmd_d = sw_wdata;
          done_d = 1'b0;
          badop_d = 1'b0;
          state_d = ST_OPC;
        end
      end
      ST_OPC: begin
        if (!known) begin
          badop_d = 1'b1;
          done_d = 1'b1;
          state_d = ST_IDLE;
        end else begin
          req_d = 1'b1;
          we_d = 1'b1;
          dwd_d = op_word(cmd_q);
          idx_d = 2'd0;
          state_d = ST_WAIT;
        end
      end
      ST_DATA: begin
        req_d = 1'b1;
        we_d = !is_read;
        dwd_d = wr_mask(cmd_q[15:8], pick_word(idx_q, wd0_q, wd1_q),
                        second_w);
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (req_q && ack_lvl_q) begin
          req_d = 1'b0;
          if (we_q == 1'b0) begin
            if (idx_q == 2'd1) begin
              rd0_d = dev_rdata;
            end else begin
              rd1_d = dev_rdata;
            end
          end
        end else if (!req_q && !ack_lvl_q) begin
          if (idx_q == n_words) begin
            state_d = ST_DONE;
          end else begin
            idx_d = idx_q + 2'd1;
            state_d = ST_DATA;
          end
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cmd_q <= tca_pkg::WORD_RESET;
      wd0_q <= tca_pkg::WORD_RESET;
      wd1_q <= tca_pkg::WORD_RESET;
      rd0_q <= tca_pkg::WORD_RESET;
      rd1_q <= tca_pkg::WORD_RESET;
      cfg_q <= tca_pkg::CFG_RESET;
      idx_q <= 2'd0;
      badop_q <= 1'b0;
      done_q <= 1'b0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      dwd_q <= tca_pkg::WORD_RESET;
      sw_rdata_q <= tca_pkg::WORD_RESET;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      wd0_q <= wd0_d;
      wd1_q <= wd1_d;
      rd0_q <= rd0_d;
      rd1_q <= rd1_d;
      cfg_q <= cfg_d;
      idx_q <= idx_d;
      badop_q <= badop_d;
      done_q <= done_d;
      req_q <= req_d;
      we_q <= we_d;
      dwd_q <= dwd_d;
      sw_rdata_q <= sw_rdata_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sw_rdata = sw_rdata_q;
  assign dev_req = req_q;
  assign dev_we = we_q;
  assign dev_wdata = dwd_q;

endmodule
`default_nettype wire

// file: verification/tca_chk.sv
/*
  Port checker for the host controller, bound into tca_host.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module tca_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  input wire logic [15:0] sw_rdata,
  input wire logic dev_req,
  input wire logic dev_we,
  input wire logic [15:0] dev_wdata,
  input wire logic [15:0] dev_rdata,
  input wire logic dev_ack
);
  // ********
  // Port relations
  // ********
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_rdata_idle: assert property (!sw_rd |=> sw_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (sw_rd && sw_addr > 4'h6 |=>
    sw_rdata == 16'h0000) else $error("unmapped read not zero");
  a_status_bits: assert property (sw_rd && sw_addr == 4'h5 |=>
    sw_rdata[15:3] == 13'h0000 && !(sw_rdata[0] && sw_rdata[1]))
    else $error("status word malformed");
  a_req_hold: assert property (dev_req && !dev_ack |=> dev_req &&
    $stable(dev_we) && $stable(dev_wdata)) else $error("request not held");
  a_req_drop: assert property (dev_req && dev_ack |-> ##[1:6] !dev_req)
    else $error("request not dropped after ack");
  a_gap_after: assert property ($fell(dev_req) |=> !dev_req [*2])
    else $error("request raised before ack released");
  a_rise_clear: assert property ($rose(dev_req) |->
    !dev_ack && !$past(dev_ack)) else $error("request raised under ack");
  a_reset_idle: assert property ($fell(reset) |->
    !dev_req && sw_rdata == 16'h0000) else $error("outputs not idle");
  c_cmd: cover property (sw_wr && sw_addr == 4'h0);
  c_dev_read: cover property (dev_req && !dev_we && dev_ack);
  c_badop: cover property (sw_rd && sw_addr == 4'h5 ##1 sw_rdata[2]);
endmodule
bind tca_host tca_chk i_tca_chk (.ref_clk(ref_clk), .reset(reset),
  .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
  .sw_rdata(sw_rdata), .dev_req(dev_req), .dev_we(dev_we),
  .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack));
`default_nettype wire

// file: verification/tca_dev_model.sv
/*
  Behavioural model of the board's opcode interpreter.
  Assumes a four-phase req/ack link clocked by ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module tca_dev_model #(
  parameter logic [15:0] ID_CODE = 16'h0000,
  parameter logic [7:0] FW_REV = 8'h13
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic narrow,
  input wire logic [3:0] delay,
  input wire logic dev_req,
  input wire logic dev_we,
  input wire logic [15:0] dev_wdata,
  output logic [15:0] dev_rdata,
  output logic dev_ack
);
  // ********
  // Opcode interpreter
  // ********
  logic [31:0] ena;
  logic [31:0] e32 [4];
  logic [15:0] gofs [2];
  logic [7:0] chofs [32];
  logic [11:0] cal [4];
  logic [11:0] saved [4];
  logic [15:0] last_op;
  logic [15:0] rv;
  logic [7:0] op;
  int rem, idx, cnt, loops;
  function automatic int words(input logic [7:0] o);
    case (o)
      8'h44, 8'h45: return narrow ? 1 : 2;
      8'h46, 8'h47, 8'h50, 8'h51: return 2;
      8'h52, 8'h53, 8'h54, 8'h55, 8'h60, 8'h61: return 1;
      default: return 0;
    endcase
  endfunction
  task automatic take(input logic [15:0] w);
    logic [1:0] n;
    logic [4:0] c;
    n = last_op[1:0];
    c = last_op[4:0];
    if (rem == 0) begin
      last_op = w;
      op = w[15:8];
      rem = words(op);
      idx = 0;
      case (op)
        8'h40: ena[w[4:0]] = 1'b1;
        8'h41: ena[w[4:0]] = 1'b0;
        8'h42: ena = '1;
        8'h43: ena = '0;
        8'h56: saved = cal;
        8'h62: loops++;
        default: ;
      endcase
    end else begin
      case (op)
        8'h44: ena[idx*16 +: 16] = w;
        8'h45: rv = ena[idx*16 +: 16];
        8'h46: e32[n][idx*16 +: 16] = w;
        8'h47: rv = e32[n][idx*16 +: 16];
        8'h50: gofs[idx] = w & (idx == 1 ? 16'h001F : 16'h07FF);
        8'h51: rv = gofs[idx];
        8'h52: chofs[c] = w[7:0];
        8'h53: rv = {8'h00, chofs[c]};
        8'h54: cal[n] = w[11:0];
        8'h55: rv = {4'h0, cal[n]};
        8'h60: rv = ID_CODE | 16'(n);
        8'h61: rv = {8'h00, FW_REV};
        default: ;
      endcase
      idx++;
      rem--;
    end
  endtask
  assign dev_rdata = dev_ack ? rv : ~rv;
  initial begin
    dev_ack = 1'b0;
    rv = 16'h0000;
  end
  always @(posedge ref_clk) begin
    if (reset) begin
      dev_ack <= 1'b0;
      rem = 0;
      cnt = 0;
      loops = 0;
      ena = '0;
      last_op = '0;
      e32 = '{default: '0};
      gofs = '{default: '0};
      chofs = '{default: '0};
      cal = '{default: '0};
      saved = '{default: '0};
    end else if (dev_req && !dev_ack) begin
      if (cnt < delay) cnt++;
      else begin
        cnt = 0;
        dev_ack <= 1'b1;
        take(dev_wdata);
      end
    end else if (dev_ack && !dev_req) begin
      dev_ack <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verification/tca_channel_adjust_opcodes_tb_top.sv
/*
  Self-checking bench for the channel-adjust host controller.
  Assumes tca_dev_model on the device side and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module tca_channel_adjust_opcodes_tb_top;
  localparam logic [15:0] ID = 16'h5A30; // Arbitrary identification value
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic narrow = 1'b0;
  logic [3:0] dly = 4'h0;
  wire logic [15:0] sw_rdata, dev_wdata, dev_rdata;
  wire logic dev_req, dev_we, dev_ack;
  int fails = 0;
  int n_compared = 0;
  int i, k;
  logic [15:0] r0, r1, w0, w1, st;
  logic [31:0] e_ena = 32'h0000_0000;
  tca_host i_tca_host (.ref_clk(ref_clk), .reset(reset), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .dev_req(dev_req), .dev_we(dev_we), .dev_wdata(dev_wdata),
    .dev_rdata(dev_rdata), .dev_ack(dev_ack));
  tca_dev_model #(.ID_CODE(ID)) i_tca_dev_model (.ref_clk(ref_clk),
    .reset(reset), .narrow(narrow), .delay(dly), .dev_req(dev_req),
    .dev_we(dev_we), .dev_wdata(dev_wdata), .dev_rdata(dev_rdata),
    .dev_ack(dev_ack));
  // ********
  // Bus tasks and checks
  // ********
  initial forever #10 ref_clk = ~ref_clk;
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask
  task automatic wait_done();
    int j;
    for (j = 0; j < 300; j++) begin
      rd(tca_pkg::REG_STATUS, st);
      if (st[1] === 1'b1) break;
    end
    if (j == 300) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic run(input logic [15:0] op, input logic [15:0] a,
                     input logic [15:0] b);
    @(posedge ref_clk);
    dly <= 4'($urandom_range(0, 7));
    wr(tca_pkg::REG_WDATA0, a);
    wr(tca_pkg::REG_WDATA1, b);
    wr(tca_pkg::REG_CMD, op);
    wait_done();
    rd(tca_pkg::REG_RDATA0, r0);
    rd(tca_pkg::REG_RDATA1, r1);
  endtask
  // ********
  // Scenarios
  // ********
  initial begin
    void'($urandom(32'hB44DD724));
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd(tca_pkg::REG_STATUS, st);
    chk(st, 16'h0000);
    rd(tca_pkg::REG_CONFIG, st);
    chk(st, tca_pkg::CFG_RESET);
    rd(4'hF, st);
    chk(st, 16'h0000);
    for (i = 0; i < 16; i++) begin
      k = $urandom_range(0, 3);
      w0 = {8'h40 + 8'(k), k < 2 ? 8'($urandom_range(0, 31)) : 8'($urandom)};
      run(w0, 16'h0000, 16'h0000);
      if (k < 2) e_ena[w0[4:0]] = (k == 0);
      else e_ena = (k == 2) ? '1 : '0;
      chk(i_tca_dev_model.last_op, k < 2 ? w0 : w0 & 16'hFF00);
      run(16'h4500, 16'h0000, 16'h0000);
      chk(r0, e_ena[15:0]);
      chk(r1, e_ena[31:16]);
    end
    w0 = 16'($urandom);
    w1 = 16'($urandom);
    run(16'h4400, w0, w1);
    run(16'h4500, 16'h0000, 16'h0000);
    chk(r0, w0);
    chk(r1, w1);
    run(16'h5000, w0, w1);
    run(16'h5100, 16'h0000, 16'h0000);
    chk(r0, w0 & 16'h07FF);
    chk(r1, w1 & 16'h001F);
    run(16'h521F, 16'hFF00 | w0, 16'h0000);
    run(16'h5200, w1, 16'h0000);
    run(16'h531F, 16'h0000, 16'h0000);
    chk({8'h00, r0[7:0]}, {8'h00, w0[7:0]});
    for (i = 0; i < 4; i++) begin
      w0 = 16'($urandom);
      w1 = 16'($urandom);
      run(16'h4600 + 16'(i), w0, w1);
      run(16'h5400 + 16'(i), w1, 16'h0000);
      run(16'h4700 + 16'(i), 16'h0000, 16'h0000);
      chk(r0, w0);
      chk(r1, w1);
      run(16'h5500 + 16'(i), 16'h0000, 16'h0000);
      chk(r0, w1 & 16'h0FFF);
      run(16'h6000 + 16'(i), 16'h0000, 16'h0000);
      chk(r0, ID | 16'(i));
    end
    run(16'h5600, 16'h0000, 16'h0000);
    chk({4'h0, i_tca_dev_model.saved[3]}, w1 & 16'h0FFF);
    run(16'h62AB, 16'h0000, 16'h0000);
    chk(16'(i_tca_dev_model.loops), 16'h0001);
    run(16'h6100, 16'h0000, 16'h0000);
    chk({8'h00, r0[7:0]}, 16'h0013);
    wr(tca_pkg::REG_CONFIG, 16'h0001);
    narrow <= 1'b1;
    run(16'h4400, w0, w1);
    run(16'h4500, 16'h0000, 16'h0000);
    chk(r0, w0);
    chk(i_tca_dev_model.last_op, 16'h4500);
    wr(tca_pkg::REG_CONFIG, 16'h0000);
    narrow <= 1'b0;
    @(posedge ref_clk);
    dly <= 4'hF;
    wr(tca_pkg::REG_WDATA0, w1);
    wr(tca_pkg::REG_CMD, 16'h4400);
    wr(tca_pkg::REG_WDATA0, ~w1);
    wr(tca_pkg::REG_CMD, 16'h4300);
    wait_done();
    run(16'h4500, 16'h0000, 16'h0000);
    chk(r0, w1);
    chk(r1, 16'h0000);
    run(16'h7700, 16'h0000, 16'h0000);
    chk(st & 16'h0007, 16'h0006);
    chk(i_tca_dev_model.last_op, 16'h4500);
    finish_test();
  end
endmodule
`default_nettype wire
